//--- logic/comm_port_defs.svh
/*
  constants of the byte handshake port: widths, byte count, phase clock
  divider and the back-to-back word gap in clock cycles.
  assumes a 250 MHz clock; times below are in picoseconds, and the gap bounds are also given in clock cycles.
*/
`ifndef COMM_PORT_DEFS_SVH
`define COMM_PORT_DEFS_SVH

// word and byte layout
`define WORD_WIDTH 32
`define BYTE_WIDTH 8
`define BYTES_PER_WORD 4
`define LAST_BYTE 2'h3
`define FIRST_BYTE 2'h0

// clock and phase clock
`define CLOCK_PERIOD_PS 4000
`define PHASE_DIV 2
`define PHASE_DIV_LAST 1'h1
`define PHASE_PERIOD_PS (`PHASE_DIV * `CLOCK_PERIOD_PS)

// ready low on last byte to strobe low on next word: 1.5 P + 7 ns .. 2.5 P + 28 ns
`define GAP_MIN_PS (3 * `PHASE_PERIOD_PS / 2 + 7000)
`define GAP_MAX_PS (5 * `PHASE_PERIOD_PS / 2 + 28000)
`define GAP_MIN_CYCLES ((`GAP_MIN_PS + `CLOCK_PERIOD_PS - 1) / `CLOCK_PERIOD_PS)
`define GAP_MAX_CYCLES (`GAP_MAX_PS / `CLOCK_PERIOD_PS)
`define GAP_WIDTH 4

// idle level of every handshake line and of the byte bus
`define LINE_IDLE 1'h1
`define BUS_IDLE 8'hFF

`endif

//--- logic/comm_port_pkg.sv
/*
  types shared by both ends of the byte handshake port.
  assumes comm_port_defs.svh for the numeric constants.
*/
package comm_port_pkg;

  // sending side: drive byte, lower strobe, raise strobe, wait ready high
  typedef enum logic [1:0] {
    SEND_IDLE,
    SEND_SETUP,
    SEND_STROBE,
    SEND_RELEASE
  } send_state_type;

  // receiving side: wait strobe low, hold ready low until strobe high
  typedef enum logic {
    RECV_WAIT,
    RECV_HELD
  } recv_state_type;

endpackage

//--- logic/comm_link_if.sv
/*
  the wires of the byte handshake link with one modport per end.
  each end drives value and enable per line; lines not driven float high
  as through a pull-up, which this interface models.
*/
`timescale 1ns/1ps

interface comm_link_if;
  // device end drivers
  logic dev_strobe_n_o;
  logic dev_strobe_oe;
  logic dev_ready_n_o;
  logic dev_ready_oe;
  logic dev_request_n_o;
  logic dev_request_oe;
  logic dev_grant_n_o;
  logic dev_grant_oe;
  logic [7:0] dev_bus_o;
  logic dev_bus_oe;
  logic dev_direction;
  // far end drivers
  logic far_strobe_n_o;
  logic far_strobe_oe;
  logic far_ready_n_o;
  logic far_ready_oe;
  logic far_request_n_o;
  logic far_request_oe;
  logic far_grant_n_o;
  logic far_grant_oe;
  logic [7:0] far_bus_o;
  logic far_bus_oe;
  // resolved line levels
  logic byte_strobe_n;
  logic byte_ready_n;
  logic token_request_n;
  logic token_grant_n;
  logic [7:0] port_byte_bus;

  // wired lines with pull-up when nobody drives
  assign byte_strobe_n = dev_strobe_oe ? dev_strobe_n_o :
                         far_strobe_oe ? far_strobe_n_o : 1'h1;
  assign byte_ready_n = dev_ready_oe ? dev_ready_n_o :
                        far_ready_oe ? far_ready_n_o : 1'h1;
  assign token_request_n = dev_request_oe ? dev_request_n_o :
                           far_request_oe ? far_request_n_o : 1'h1;
  assign token_grant_n = dev_grant_oe ? dev_grant_n_o :
                         far_grant_oe ? far_grant_n_o : 1'h1;
  assign port_byte_bus = dev_bus_oe ? dev_bus_o :
                         far_bus_oe ? far_bus_o : 8'hFF;

  modport device (
    output dev_strobe_n_o, dev_strobe_oe, dev_ready_n_o, dev_ready_oe,
    output dev_request_n_o, dev_request_oe, dev_grant_n_o, dev_grant_oe,
    output dev_bus_o, dev_bus_oe, dev_direction,
    input byte_strobe_n, byte_ready_n, token_request_n, token_grant_n, port_byte_bus
  );

  modport partner (
    output far_strobe_n_o, far_strobe_oe, far_ready_n_o, far_ready_oe,
    output far_request_n_o, far_request_oe, far_grant_n_o, far_grant_oe,
    output far_bus_o, far_bus_oe,
    input byte_strobe_n, byte_ready_n, token_request_n, token_grant_n, port_byte_bus
  );
endinterface

//--- logic/comm_port_device.sv
/*
  device end of the byte handshake port: sends or receives 32-bit words as
  four interlocked byte transfers, direction fixed at reset by port number
  and swapped on request while idle.
  assumes comm_link_if carries the lines and the partner keeps its half of
  the four-phase handshake; the partner's lines are asynchronous.
*/
`timescale 1ns/1ps
`include "comm_port_defs.svh"

// Behaviour
// RULE1 - word moves as four fully handshaked bytes
// RULE2 - every word starts at byte zero
// RULE3 - data valid on bus before strobe low
// RULE4 - receiver captures byte then lowers ready
// RULE5 - sender holds byte until ready low, then raises strobe
// RULE6 - receiver raises ready after strobe high
// RULE7 - next strobe low only after ready high
// RULE8 - back-to-back word gap 1.5P+7 to 2.5P+28 ns; only the minimum is held, via GAP_MIN_CYCLES, no maximum
// RULE9 - no handshake timeout, wait for edges
// RULE10 - sample partner inputs on phase clock fall
// RULE11 - ports one, two send; four, five receive
// RULE12 - direction swap turns request/ready and strobe/grant/data
// RULE13 - two-stage synchroniser on every handshake input
// RULE14 - byte zero is least significant byte
module comm_port_device #(
  parameter int unsigned PORT_NUMBER = 1
) (
  input wire logic clock,
  input wire logic nrst,
  comm_link_if.device link,
  input wire logic [31:0] tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [31:0] rx_word,
  output logic rx_valid,
  input wire logic swap_dir,
  output logic sending
);

  localparam logic RESET_SENDER = (PORT_NUMBER == 1) || (PORT_NUMBER == 2);
  localparam logic [`GAP_WIDTH-1:0] GAP_LOAD = `GAP_WIDTH'(`GAP_MIN_CYCLES);

  // synchroniser and phase sampling state; bit 1 strobe, bit 0 ready
  logic [1:0] sync_first;
  logic [1:0] sync_second;
  logic [1:0] sampled;
  logic [1:0] next_sampled;
  logic phase_count;
  logic next_phase_count;
  logic phase_fall;

  // port state
  comm_port_pkg::send_state_type send_state;
  comm_port_pkg::send_state_type next_send_state;
  comm_port_pkg::recv_state_type recv_state;
  comm_port_pkg::recv_state_type next_recv_state;
  logic is_sender;
  logic next_is_sender;
  logic [1:0] byte_index;
  logic [1:0] next_byte_index;
  logic [31:0] word_hold;
  logic [31:0] next_word_hold;
  logic [7:0] bus_out;
  logic [7:0] next_bus_out;
  logic strobe_out;
  logic next_strobe_out;
  logic ready_out;
  logic next_ready_out;
  logic [`GAP_WIDTH-1:0] gap_count;
  logic [`GAP_WIDTH-1:0] next_gap_count;
  logic [31:0] next_rx_word;
  logic next_rx_valid;
  logic strobe_low;
  logic ready_low;
  logic idle;

  // phase clock divider and sampling point on its falling edge
  always_comb
  begin
    phase_fall = (phase_count == `PHASE_DIV_LAST);
    next_phase_count = phase_fall ? 1'h0 : phase_count + 1'h1;
    next_sampled = phase_fall ? sync_second : sampled; // RULE10
  end

  // two flops per input, then the phase-sampled copy
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      sync_first <= 2'h3;
      sync_second <= 2'h3;
      sampled <= 2'h3;
      phase_count <= 1'h0;
    end
    else
    begin
      sync_first <= {link.byte_strobe_n, link.byte_ready_n}; // RULE13
      sync_second <= sync_first; // RULE13
      sampled <= next_sampled;
      phase_count <= next_phase_count;
    end
  end

  assign strobe_low = !sampled[1];
  assign ready_low = !sampled[0];
  assign idle = (send_state == comm_port_pkg::SEND_IDLE) &&
                (recv_state == comm_port_pkg::RECV_WAIT) && (gap_count == '0);

  // take a new word only when the line is quiet and the gap has run out
  assign tx_ready = is_sender && idle && !ready_low; // RULE7 RULE8

  // handshake sequencing for both directions
  always_comb
  begin
    next_send_state = send_state;
    next_recv_state = recv_state;
    next_is_sender = is_sender;
    next_byte_index = byte_index;
    next_word_hold = word_hold;
    next_bus_out = bus_out;
    next_strobe_out = strobe_out;
    next_ready_out = ready_out;
    next_gap_count = (gap_count == '0) ? gap_count : gap_count - 1'h1;
    next_rx_word = rx_word;
    next_rx_valid = 1'h0;
    if (idle && swap_dir)
    begin
      next_is_sender = !is_sender; // RULE12
      next_byte_index = `FIRST_BYTE;
    end
    unique case (send_state)
      comm_port_pkg::SEND_IDLE:
      begin
        if (tx_ready && tx_valid)
        begin
          next_word_hold = tx_word;
          next_bus_out = tx_word[7:0]; // RULE2 RULE14
          next_byte_index = `FIRST_BYTE; // RULE2
          next_send_state = comm_port_pkg::SEND_SETUP;
        end
      end
      comm_port_pkg::SEND_SETUP:
      begin
        // data has stood one cycle before the strobe falls
        next_strobe_out = 1'h0; // RULE3
        next_send_state = comm_port_pkg::SEND_STROBE;
      end
      comm_port_pkg::SEND_STROBE:
      begin
        // no timeout: wait as long as the receiver needs
        if (ready_low) // RULE5 RULE9
        begin
          next_strobe_out = 1'h1; // RULE5
          if (byte_index == `LAST_BYTE)
          begin
            next_gap_count = GAP_LOAD; // RULE8
          end
          next_send_state = comm_port_pkg::SEND_RELEASE;
        end
      end
      comm_port_pkg::SEND_RELEASE:
      begin
        if (!ready_low) // RULE7
        begin
          if (byte_index == `LAST_BYTE)
          begin
            next_byte_index = `FIRST_BYTE;
            next_send_state = comm_port_pkg::SEND_IDLE;
          end
          else
          begin
            next_byte_index = byte_index + 2'h1; // RULE1
            next_bus_out = word_hold[8 * (byte_index + 2'h1) +: 8]; // RULE14
            next_send_state = comm_port_pkg::SEND_SETUP;
          end
        end
      end
    endcase
    unique case (recv_state)
      comm_port_pkg::RECV_WAIT:
      begin
        if (!is_sender && strobe_low)
        begin
          next_word_hold[8 * byte_index +: 8] = link.port_byte_bus; // RULE4 RULE14
          next_ready_out = 1'h0; // RULE4
          next_recv_state = comm_port_pkg::RECV_HELD;
        end
      end
      comm_port_pkg::RECV_HELD:
      begin
        if (!strobe_low) // RULE6 RULE9
        begin
          next_ready_out = 1'h1; // RULE6
          next_recv_state = comm_port_pkg::RECV_WAIT;
          if (byte_index == `LAST_BYTE)
          begin
            next_rx_word = word_hold; // RULE1
            next_rx_valid = 1'h1;
            next_byte_index = `FIRST_BYTE; // RULE2
          end
          else
          begin
            next_byte_index = byte_index + 2'h1;
          end
        end
      end
    endcase
  end

  // port registers
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      send_state <= comm_port_pkg::SEND_IDLE;
      recv_state <= comm_port_pkg::RECV_WAIT;
      is_sender <= RESET_SENDER; // RULE11
      byte_index <= `FIRST_BYTE;
      word_hold <= 32'h00000000;
      bus_out <= `BUS_IDLE;
      strobe_out <= `LINE_IDLE;
      ready_out <= `LINE_IDLE;
      gap_count <= '0;
      rx_word <= 32'h00000000;
      rx_valid <= 1'h0;
    end
    else
    begin
      send_state <= next_send_state;
      recv_state <= next_recv_state;
      is_sender <= next_is_sender;
      byte_index <= next_byte_index;
      word_hold <= next_word_hold;
      bus_out <= next_bus_out;
      strobe_out <= next_strobe_out;
      ready_out <= next_ready_out;
      gap_count <= next_gap_count;
      rx_word <= next_rx_word;
      rx_valid <= next_rx_valid;
    end
  end

  // line drivers: sender owns strobe, grant, data; receiver request, ready
  assign link.dev_strobe_n_o = strobe_out;
  assign link.dev_strobe_oe = is_sender; // RULE12
  assign link.dev_grant_n_o = `LINE_IDLE;
  assign link.dev_grant_oe = is_sender; // RULE12
  assign link.dev_bus_o = bus_out;
  assign link.dev_bus_oe = is_sender; // RULE12
  assign link.dev_ready_n_o = ready_out;
  assign link.dev_ready_oe = !is_sender; // RULE12
  assign link.dev_request_n_o = `LINE_IDLE;
  assign link.dev_request_oe = !is_sender; // RULE12
  assign link.dev_direction = !is_sender; // high while receiving
  assign sending = is_sender;

endmodule // comm_port_device

//--- logic/comm_port_partner.sv
/*
  far end of the byte handshake port: compatible logic that sends or
  receives 32-bit words as four interlocked bytes.
  assumes comm_link_if carries the lines; device lines are synchronised.
*/
`timescale 1ns/1ps
`include "comm_port_defs.svh"

module comm_port_partner #(
  parameter bit START_AS_SENDER = 1'b0
) (
  input wire logic clock,
  input wire logic nrst,
  comm_link_if.partner link,
  input wire logic [31:0] tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [31:0] rx_word,
  output logic rx_valid,
  input wire logic swap_dir,
  output logic sending
);

  // synchroniser, bit 1 strobe, bit 0 ready
  logic [1:0] sync_first;
  logic [1:0] sync_second;
  comm_port_pkg::send_state_type send_state;
  comm_port_pkg::send_state_type next_send_state;
  comm_port_pkg::recv_state_type recv_state;
  comm_port_pkg::recv_state_type next_recv_state;
  logic is_sender;
  logic next_is_sender;
  logic [1:0] byte_index;
  logic [1:0] next_byte_index;
  logic [31:0] word_hold;
  logic [31:0] next_word_hold;
  logic [7:0] bus_out;
  logic [7:0] next_bus_out;
  logic strobe_out;
  logic next_strobe_out;
  logic ready_out;
  logic next_ready_out;
  logic [31:0] next_rx_word;
  logic next_rx_valid;
  logic strobe_low;
  logic ready_low;
  logic idle;

  assign strobe_low = !sync_second[1];
  assign ready_low = !sync_second[0];
  assign idle = (send_state == comm_port_pkg::SEND_IDLE) &&
                (recv_state == comm_port_pkg::RECV_WAIT);
  assign tx_ready = is_sender && idle && !ready_low; // RULE7

  // four-phase sequencing, same byte order as the device
  always_comb
  begin
    next_send_state = send_state;
    next_recv_state = recv_state;
    next_is_sender = is_sender;
    next_byte_index = byte_index;
    next_word_hold = word_hold;
    next_bus_out = bus_out;
    next_strobe_out = strobe_out;
    next_ready_out = ready_out;
    next_rx_word = rx_word;
    next_rx_valid = 1'h0;
    if (idle && swap_dir)
    begin
      next_is_sender = !is_sender; // RULE12
      next_byte_index = `FIRST_BYTE;
    end
    unique case (send_state)
      comm_port_pkg::SEND_IDLE:
      begin
        if (tx_ready && tx_valid)
        begin
          next_word_hold = tx_word;
          next_bus_out = tx_word[7:0]; // RULE2 RULE14
          next_byte_index = `FIRST_BYTE;
          next_send_state = comm_port_pkg::SEND_SETUP;
        end
      end
      comm_port_pkg::SEND_SETUP:
      begin
        next_strobe_out = 1'h0; // RULE3
        next_send_state = comm_port_pkg::SEND_STROBE;
      end
      comm_port_pkg::SEND_STROBE:
      begin
        if (ready_low) // RULE5 RULE9
        begin
          next_strobe_out = 1'h1;
          next_send_state = comm_port_pkg::SEND_RELEASE;
        end
      end
      comm_port_pkg::SEND_RELEASE:
      begin
        if (!ready_low) // RULE7
        begin
          if (byte_index == `LAST_BYTE)
          begin
            next_byte_index = `FIRST_BYTE;
            next_send_state = comm_port_pkg::SEND_IDLE;
          end
          else
          begin
            next_byte_index = byte_index + 2'h1; // RULE1
            next_bus_out = word_hold[8 * (byte_index + 2'h1) +: 8];
            next_send_state = comm_port_pkg::SEND_SETUP;
          end
        end
      end
    endcase
    unique case (recv_state)
      comm_port_pkg::RECV_WAIT:
      begin
        if (!is_sender && strobe_low)
        begin
          next_word_hold[8 * byte_index +: 8] = link.port_byte_bus; // RULE4
          next_ready_out = 1'h0; // RULE4
          next_recv_state = comm_port_pkg::RECV_HELD;
        end
      end
      comm_port_pkg::RECV_HELD:
      begin
        if (!strobe_low) // RULE6
        begin
          next_ready_out = 1'h1;
          next_recv_state = comm_port_pkg::RECV_WAIT;
          next_byte_index = byte_index + 2'h1;
          if (byte_index == `LAST_BYTE)
          begin
            next_rx_word = word_hold; // RULE1
            next_rx_valid = 1'h1;
          end
        end
      end
    endcase
  end

  // registers, synchroniser included
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      sync_first <= 2'h3;
      sync_second <= 2'h3;
      send_state <= comm_port_pkg::SEND_IDLE;
      recv_state <= comm_port_pkg::RECV_WAIT;
      is_sender <= START_AS_SENDER;
      byte_index <= `FIRST_BYTE;
      word_hold <= 32'h00000000;
      bus_out <= `BUS_IDLE;
      strobe_out <= `LINE_IDLE;
      ready_out <= `LINE_IDLE;
      rx_word <= 32'h00000000;
      rx_valid <= 1'h0;
    end
    else
    begin
      sync_first <= {link.byte_strobe_n, link.byte_ready_n}; // RULE13
      sync_second <= sync_first;
      send_state <= next_send_state;
      recv_state <= next_recv_state;
      is_sender <= next_is_sender;
      byte_index <= next_byte_index;
      word_hold <= next_word_hold;
      bus_out <= next_bus_out;
      strobe_out <= next_strobe_out;
      ready_out <= next_ready_out;
      rx_word <= next_rx_word;
      rx_valid <= next_rx_valid;
    end
  end

  // line drivers follow direction
  assign link.far_strobe_n_o = strobe_out;
  assign link.far_strobe_oe = is_sender; // RULE12
  assign link.far_grant_n_o = `LINE_IDLE;
  assign link.far_grant_oe = is_sender;
  assign link.far_bus_o = bus_out;
  assign link.far_bus_oe = is_sender;
  assign link.far_ready_n_o = ready_out;
  assign link.far_ready_oe = !is_sender; // RULE12
  assign link.far_request_n_o = `LINE_IDLE;
  assign link.far_request_oe = !is_sender;
  assign sending = is_sender;

endmodule // comm_port_partner

//--- verif/comm_port_checker.sv
/*
  wire checks on one byte handshake link, device end facing partner end.
  assumes signals taken straight from comm_link_if, one clock domain.
*/
`timescale 1ns/1ps

module comm_port_checker (
  input wire logic clock,
  input wire logic nrst,
  input wire logic byte_strobe_n,
  input wire logic byte_ready_n,
  input wire logic token_request_n,
  input wire logic token_grant_n,
  input wire logic [7:0] port_byte_bus,
  input wire logic dev_direction,
  input wire logic dev_strobe_n_o,
  input wire logic dev_strobe_oe,
  input wire logic dev_ready_oe,
  input wire logic [7:0] dev_bus_o,
  input wire logic dev_bus_oe
);
  localparam int GAP_MIN_WIRE = 5;
  logic strobe_prev, ready_prev, gap_on;
  logic [1:0] ready_falls;
  logic [7:0] gap_count;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // counts acknowledged bytes and cycles since a word's last acknowledge
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      strobe_prev <= 1'h1;
      ready_prev <= 1'h1;
      gap_on <= 1'h0;
      ready_falls <= 2'h0;
      gap_count <= 8'h00;
    end
    else
    begin
      strobe_prev <= byte_strobe_n;
      ready_prev <= byte_ready_n;
      if (ready_prev && !byte_ready_n)
      begin
        ready_falls <= ready_falls + 2'h1;
      end
      if (ready_prev && !byte_ready_n && ready_falls == 2'h3)
      begin
        gap_on <= 1'h1;
        gap_count <= 8'h00;
      end
      else
      begin
        gap_on <= gap_on && !(strobe_prev && !byte_strobe_n);
        gap_count <= (gap_count == 8'hFF) ? gap_count : gap_count + 8'h01;
      end
    end
  end

  property p_setup;
    $fell(dev_strobe_n_o) && dev_strobe_oe |-> $stable(dev_bus_o);
  endproperty
  a_setup: assert property (p_setup) else $error("byte moved at strobe");

  property p_bus_held;
    (!byte_strobe_n && !$past(byte_strobe_n)) || (!byte_ready_n && !$past(byte_ready_n))
      |-> $stable(port_byte_bus);
  endproperty
  a_bus_held: assert property (p_bus_held) else $error("byte not held");

  property p_strobe_held;
    !byte_strobe_n && byte_ready_n |=> !byte_strobe_n;
  endproperty
  a_strobe_held: assert property (p_strobe_held) else $error("strobe rose early");

  property p_sync_delay;
    $fell(byte_strobe_n) |-> byte_ready_n [*2];
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("ready too fast");

  property p_ready_answer;
    $fell(byte_strobe_n) |-> ##[1:12] !byte_ready_n;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("no ready low");

  property p_ready_held;
    !byte_ready_n && !byte_strobe_n |=> !byte_ready_n;
  endproperty
  a_ready_held: assert property (p_ready_held) else $error("ready rose early");

  property p_ready_release;
    $rose(byte_strobe_n) |-> ##[1:12] byte_ready_n;
  endproperty
  a_ready_release: assert property (p_ready_release) else $error("ready stuck");

  property p_next_strobe;
    byte_strobe_n && !byte_ready_n |=> byte_strobe_n;
  endproperty
  a_next_strobe: assert property (p_next_strobe) else $error("strobe before ready");

  property p_word_gap;
    strobe_prev && !byte_strobe_n && gap_on && dev_strobe_oe
      |-> {1'h0, gap_count} + 9'h001 >= 9'(GAP_MIN_WIRE);
  endproperty
  a_word_gap: assert property (p_word_gap) else $error("word gap short");

  property p_reset_state;
    $rose(nrst) |-> byte_strobe_n && byte_ready_n && port_byte_bus == 8'hFF && !dev_direction;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");

  property p_line_owner;
    $stable(dev_direction) |-> dev_ready_oe == dev_direction && dev_strobe_oe == !dev_direction
      && dev_bus_oe == !dev_direction && token_request_n && token_grant_n;
  endproperty
  a_line_owner: assert property (p_line_owner) else $error("wrong line owner");

  c_byte: cover property ($fell(byte_strobe_n));
  c_swap: cover property ($rose(dev_direction));
  c_gap: cover property (strobe_prev && !byte_strobe_n && gap_on);
endmodule // comm_port_checker

//--- verif/byte_handshake_comm_port_test.sv
/*
  self-checking bench: device and partner ends on one link, and a second
  device end fed by a slow sender of the bench.
  assumes the design under logic/ and a 250 MHz clock.
*/
`timescale 1ns/1ps

module byte_handshake_comm_port_test;
  logic clock;
  logic nrst;
  logic [31:0] dv_tx_word, dv_rx_word, pt_tx_word, pt_rx_word, rb_rx_word, seed;
  logic dv_tx_valid, dv_tx_ready, dv_rx_valid, dv_swap, dv_sending;
  logic pt_tx_valid, pt_tx_ready, pt_rx_valid, pt_swap, pt_sending;
  logic rb_rx_valid, rb_sending, strobe_seen, rb_poke;
  logic [31:0] dv_exp[$], pt_exp[$], rb_exp[$], wire_exp[$];
  logic [31:0] corner[4] = '{32'h00000000, 32'hFFFFFFFF, 32'h03020100, 32'h80000001};
  int num_errors, samples_checked, cycles, wire_count;

  comm_link_if link_a ();
  comm_link_if link_b ();
  comm_port_device #(.PORT_NUMBER(1)) i_comm_port_device (.clock(clock), .nrst(nrst),
    .link(link_a), .tx_word(dv_tx_word), .tx_valid(dv_tx_valid), .tx_ready(dv_tx_ready),
    .rx_word(dv_rx_word), .rx_valid(dv_rx_valid), .swap_dir(dv_swap), .sending(dv_sending));
  comm_port_partner #(.START_AS_SENDER(1'h0)) i_comm_port_partner (.clock(clock), .nrst(nrst),
    .link(link_a), .tx_word(pt_tx_word), .tx_valid(pt_tx_valid), .tx_ready(pt_tx_ready),
    .rx_word(pt_rx_word), .rx_valid(pt_rx_valid), .swap_dir(pt_swap), .sending(pt_sending));
  comm_port_device #(.PORT_NUMBER(4)) i_comm_port_device_b (.clock(clock), .nrst(nrst),
    .link(link_b), .tx_word(seed), .tx_valid(rb_poke), .tx_ready(),
    .rx_word(rb_rx_word), .rx_valid(rb_rx_valid), .swap_dir(rb_poke), .sending(rb_sending));
  comm_port_checker i_comm_port_checker (.clock(clock), .nrst(nrst),
    .byte_strobe_n(link_a.byte_strobe_n), .byte_ready_n(link_a.byte_ready_n),
    .token_request_n(link_a.token_request_n), .token_grant_n(link_a.token_grant_n),
    .port_byte_bus(link_a.port_byte_bus), .dev_direction(link_a.dev_direction),
    .dev_strobe_n_o(link_a.dev_strobe_n_o), .dev_strobe_oe(link_a.dev_strobe_oe),
    .dev_ready_oe(link_a.dev_ready_oe), .dev_bus_o(link_a.dev_bus_o),
    .dev_bus_oe(link_a.dev_bus_oe));

  // free running clock
  initial
  begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    samples_checked++;
    if (seen !== expected)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic stall();
    num_errors++;
    $display("[ERR] %0t wait ran out", $time);
  endtask

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [31:0] byte_of(input logic [31:0] w, input int k);
    return {24'h000000, w[8 * k +: 8]};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hand one word to the chosen end once it can take it
  task automatic send_word(input logic from_dev, input logic [31:0] w);
    int n = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end
    while ((from_dev ? dv_tx_ready : pt_tx_ready) !== 1'h1 && n < 400);
    if (n >= 400) stall();
    if (from_dev)
    begin
      dv_tx_word = w;
      dv_tx_valid = 1'h1;
      pt_exp.push_back(w);
    end
    else
    begin
      pt_tx_word = w;
      pt_tx_valid = 1'h1;
      dv_exp.push_back(w);
    end
    wire_exp.push_back(w);
    @(posedge clock);
    #1;
    dv_tx_valid = 1'h0;
    pt_tx_valid = 1'h0;
  endtask

  task automatic wait_drain();
    int n = 0;
    while (dv_exp.size() + pt_exp.size() + rb_exp.size() != 0 && n < 2000)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 2000) stall();
  endtask

  // turn both ends round together while the link is idle
  task automatic swap_ends(input logic dev_sends);
    int n = 0;
    while ((dev_sends ? pt_tx_ready : dv_tx_ready) !== 1'h1 && n < 400)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 400) stall();
    dv_swap = 1'h1;
    pt_swap = 1'h1;
    @(posedge clock);
    #1;
    dv_swap = 1'h0;
    pt_swap = 1'h0;
    check(dv_sending, dev_sends);
    check(pt_sending, !dev_sends);
    check(link_a.dev_direction, !dev_sends);
  endtask

  task automatic wait_b_ready(input logic level);
    int n = 0;
    while (link_b.byte_ready_n !== level && n < 400)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 400) stall();
  endtask

  // slow sender on the second link, holding each strobe low for stretch cycles after ready falls
  task automatic far_send(input logic [31:0] w, input int stretch);
    rb_exp.push_back(w);
    for (int k = 0; k < 4; k++)
    begin
      link_b.far_bus_o = w[8 * k +: 8];
      link_b.far_bus_oe = 1'h1;
      @(posedge clock);
      #1;
      link_b.far_strobe_n_o = 1'h0;
      wait_b_ready(1'h0);
      rb_poke = 1'h1;
      repeat (stretch) @(posedge clock);
      #1;
      rb_poke = 1'h0;
      check(rb_sending, 1'h0);
      check(link_b.byte_ready_n, 1'h0);
      link_b.far_strobe_n_o = 1'h1;
      wait_b_ready(1'h1);
    end
    link_b.far_bus_oe = 1'h0;
  endtask

  // delivered words, bytes on the wire and the run limit
  always @(posedge clock)
  begin
    cycles++;
    if (pt_rx_valid === 1'h1) check(pt_rx_word, pt_exp.pop_front());
    if (dv_rx_valid === 1'h1) check(dv_rx_word, dv_exp.pop_front());
    if (rb_rx_valid === 1'h1) check(rb_rx_word, rb_exp.pop_front());
    strobe_seen <= link_a.byte_strobe_n;
    if (strobe_seen === 1'h1 && link_a.byte_strobe_n === 1'h0)
    begin
      check(link_a.port_byte_bus, byte_of(wire_exp[0], wire_count));
      wire_count = (wire_count + 1) % 4;
      if (wire_count == 0) wire_exp.delete(0);
    end
    if (cycles == 20000)
    begin
      stall();
      report_and_stop();
    end
  end

  initial
  begin
    nrst = 1'h0;
    seed = 32'hF30B;
    {dv_tx_word, pt_tx_word} = 64'h0;
    {dv_tx_valid, pt_tx_valid, dv_swap, pt_swap, rb_poke} = 5'h00;
    {link_b.far_strobe_n_o, link_b.far_ready_n_o} = 2'h3;
    {link_b.far_request_n_o, link_b.far_grant_n_o} = 2'h3;
    {link_b.far_strobe_oe, link_b.far_grant_oe} = 2'h3;
    {link_b.far_ready_oe, link_b.far_request_oe, link_b.far_bus_oe} = 3'h0;
    link_b.far_bus_o = 8'hFF;
    repeat (3) @(posedge clock);
    #1;
    nrst = 1'h1;
    check(dv_sending, 1'h1);
    check(pt_sending, 1'h0);
    check(rb_sending, 1'h0);
    $display("test reset done");
    foreach (corner[i]) send_word(1'h1, corner[i]);
    repeat (8)
    begin
      seed = xorshift(seed);
      send_word(1'h1, seed);
    end
    wait_drain();
    $display("test device send done");
    swap_ends(1'h0);
    for (int i = 0; i < 6; i++)
    begin
      seed = xorshift(seed);
      send_word(1'h0, (i < 4) ? corner[i] : seed);
    end
    wait_drain();
    swap_ends(1'h1);
    send_word(1'h1, corner[2]);
    wait_drain();
    $display("test swap done");
    far_send(corner[2], 0);
    seed = xorshift(seed);
    far_send(seed, 40);
    wait_drain();
    $display("test slow sender done");
    report_and_stop();
  end
endmodule // byte_handshake_comm_port_test
